// ### logic/hcp_pkg.sv
// hcp_pkg: shared codes, defaults, field layouts and timing for the
// two-channel HART poll and channel configuration block.
// assumes one 100 MHz clock and a HART modem that frames and sends the bytes.
// How it works
// - on HART start-up a channel first asks for identification (0), then tag (13).
// - start-up reply data goes to diagnostic record 131 (channel 0) or 151 (channel 1).
// - in normal operation command 1 is sent again and again, each PV to user data.
// - the activity indicator is on only while HART is selected and talking.
// - limits are held per channel within 32511..-32512, defaults 32767 and -32767.
// - measurement type is off, four-wire, two-wire or HART, HART by default.
// - range is 4-20 mA by default; on input modules 0-20 mA only with four-wire transmitter mode.
// - on controller stop an output goes to zero, holds, or takes a substitute.
// - stop reaction defaults to substitute; substitute is 0..20 mA, 0 mA default.
// - output mode is off, current or HART; HART makes the channel a master.
// - a reported parameter change raises a diagnostic interrupt when enabled.
package hcp_pkg;
    localparam int NCH = 2;
    localparam logic [7:0] CMD_IDENT = 8'h00;
    localparam logic [7:0] CMD_READ_PV = 8'h01;
    localparam logic [7:0] CMD_TAG = 8'h0D;
    localparam logic [7:0] REC_DIAG_CH0 = 8'h83;
    localparam logic [7:0] REC_DIAG_CH1 = 8'h97;
    localparam int ST_CFG_CHANGED = 6;
    localparam logic signed [15:0] LIM_TOP = 16'sh7EFF;
    localparam logic signed [15:0] LIM_BOT = 16'sh8100;
    localparam logic signed [15:0] HI_DEFAULT = 16'sh7FFF;
    localparam logic signed [15:0] LO_DEFAULT = 16'sh8001;
    localparam logic signed [15:0] SUBST_TOP = 16'sh4E20; // 20 mA in uA
    localparam logic signed [15:0] SUBST_DEFAULT = 16'sh0000;
    localparam int CLK_HZ = 100_000_000;
    localparam int RSP_TIMEOUT_MS = 500;
    localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        meas_off = 2'h0,
        four_wire_transmitter_mode = 2'h1,
        two_wire_transmitter_mode = 2'h2,
        meas_hart = 2'h3
    } hcp_meas_e;
    typedef enum logic {range_4_20 = 1'h0, range_0_20 = 1'h1} hcp_range_e;
    typedef enum logic [1:0] {
        integ_2m5 = 2'h0,
        integ_16m6 = 2'h1,
        integ_20m = 2'h2,
        integ_100m = 2'h3
    } hcp_integ_e;
    typedef enum logic [1:0] {
        stop_zero_output = 2'h0,
        stop_hold_last = 2'h1,
        stop_apply_substitute = 2'h2
    } hcp_stop_e;
    typedef enum logic [1:0] {out_off = 2'h0, out_current = 2'h1, out_hart = 2'h2} hcp_out_e;
    typedef enum logic [3:0] {
        ph_off = 4'b0001,
        ph_ident = 4'b0010,
        ph_tag = 4'b0100,
        ph_run = 4'b1000
    } hcp_phase_e;
    typedef enum logic [2:0] {sq_pick = 3'b001, sq_send = 3'b010, sq_wait = 3'b100} hcp_seq_e;

    typedef struct packed {
        hcp_meas_e meas;
        hcp_range_e range;
        hcp_integ_e integ;
        logic signed [15:0] hi;
        logic signed [15:0] lo;
        hcp_stop_e stop;
        logic signed [15:0] subst;
        hcp_out_e out_mode;
    } hcp_chan_cfg_s;
    typedef struct packed {
        logic diag_en;
        logic limit_en;
        logic eoc_en;
    } hcp_mod_cfg_s;
    typedef struct packed {
        logic chan;
        logic [7:0] code;
    } hcp_cmd_s;
    typedef struct packed {
        logic chan;
        logic [7:0] code;
        logic ok;
        logic [7:0] status;
        logic [63:0] data;
    } hcp_rsp_s;
    typedef struct packed {
        logic [7:0] num;
        logic [7:0] code;
        logic [63:0] data;
    } hcp_rec_s;

    localparam hcp_chan_cfg_s CFG_DEFAULT = '{meas: meas_hart, range: range_4_20,
        integ: integ_20m, hi: HI_DEFAULT, lo: LO_DEFAULT, stop: stop_apply_substitute,
        subst: SUBST_DEFAULT, out_mode: out_hart};
    localparam hcp_mod_cfg_s MOD_DEFAULT = '{diag_en: 1'h0, limit_en: 1'h0, eoc_en: 1'h0};

    // signed saturation, shared by limit and substitute loading
    function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction
endpackage

// ### logic/hcp_chan_cfg.sv
// hcp_chan_cfg: one channel's settings, limit check and stop reaction.
// assumes pv_we pulses once per fresh primary value from the poller.
`timescale 1ns/100ps
module hcp_chan_cfg import hcp_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic out_module,
    input wire logic cfg_we,
    input wire hcp_chan_cfg_s cfg_wdata,
    output hcp_chan_cfg_s cfg,
    output logic hart_sel,
    input wire logic pv_we,
    input wire logic signed [15:0] pv_value,
    output logic hi_exceed,
    output logic lo_exceed,
    input wire logic cpu_stop,
    input wire logic signed [15:0] ao_setpoint,
    output logic signed [15:0] ao_drive
);
    hcp_chan_cfg_s cfg_r;
    hcp_chan_cfg_s cfg_nxt;
    logic hi_r;
    logic lo_r;
    logic signed [15:0] drive_r;

    // sanitize on load so illegal settings never reach the channel
    always_comb begin
        cfg_nxt = cfg_wdata;
        cfg_nxt.hi = (cfg_wdata.hi == HI_DEFAULT) ? HI_DEFAULT
                   : clamp16(cfg_wdata.hi, LIM_BOT, LIM_TOP);
        cfg_nxt.lo = (cfg_wdata.lo == LO_DEFAULT) ? LO_DEFAULT
                   : clamp16(cfg_wdata.lo, LIM_BOT, LIM_TOP);
        if (!out_module && cfg_wdata.meas != four_wire_transmitter_mode) begin
            cfg_nxt.range = range_4_20;
        end
        cfg_nxt.subst = clamp16(cfg_wdata.subst, SUBST_DEFAULT, SUBST_TOP);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_r <= CFG_DEFAULT;
        end else if (cfg_we) begin
            cfg_r <= cfg_nxt;
        end
    end

    assign hart_sel = out_module ? (cfg_r.out_mode == out_hart) : (cfg_r.meas == meas_hart);
    assign cfg = cfg_r;

    // limit compare on each new value, input modules only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
        end else begin
            hi_r <= pv_we && !out_module && (pv_value > cfg_r.hi);
            lo_r <= pv_we && !out_module && (pv_value < cfg_r.lo);
        end
    end
    assign hi_exceed = hi_r;
    assign lo_exceed = lo_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            drive_r <= SUBST_DEFAULT;
        end else if (!cpu_stop) begin
            drive_r <= (cfg_r.out_mode == out_off) ? 16'sh0000 : ao_setpoint;
        end else if (cfg_r.stop == stop_zero_output) begin
            drive_r <= 16'sh0000;
        end else if (cfg_r.stop == stop_apply_substitute) begin
            drive_r <= cfg_r.subst;
        end
    end
    assign ao_drive = drive_r;

    AST_STOP_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        cpu_stop && cfg_r.stop == stop_zero_output |=> drive_r == 16'sh0000)
        else $error("stop zero not applied");
    AST_STOP_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
        cpu_stop && cfg_r.stop == stop_hold_last |=> $stable(drive_r))
        else $error("stop hold changed output");
    AST_LIMIT_SPAN: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_r.hi == HI_DEFAULT || (cfg_r.hi <= LIM_TOP && cfg_r.hi >= LIM_BOT)))
        else $error("high limit out of span");
    AST_RANGE_GUARD: assert property (@(posedge sys_clk) disable iff (reset)
        !out_module && cfg_r.range == range_0_20 |-> cfg_r.meas == four_wire_transmitter_mode)
        else $error("0-20 mA without four-wire mode");
    AST_SUBST_SPAN: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_r.subst >= SUBST_DEFAULT && cfg_r.subst <= SUBST_TOP)
        else $error("substitute out of span");
endmodule

// ### logic/hcp_poll_top.sv
// hcp_poll_top: HART master sequencer and settings for two current-loop channels.
// assumes a modem that takes one framed command at a time and returns at most
// one reply per command; out_module is a strap held steady while running.
`timescale 1ns/100ps
module hcp_poll_top import hcp_pkg::*; #(
    parameter int RSP_TIMEOUT = RSP_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic out_module,
    input wire logic mod_cfg_we,
    input wire hcp_mod_cfg_s mod_cfg_wdata,
    input wire logic [NCH-1:0] cfg_we,
    input wire hcp_chan_cfg_s cfg_wdata,
    output hcp_chan_cfg_s chan_cfg [NCH],
    input wire logic cpu_stop,
    input wire logic signed [15:0] ao_setpoint [NCH],
    output logic signed [15:0] ao_drive [NCH],
    output logic cmd_valid,
    input wire logic cmd_ready,
    output hcp_cmd_s cmd,
    input wire logic rsp_valid,
    input wire hcp_rsp_s rsp,
    output logic rec_we,
    output hcp_rec_s rec,
    output logic pv_we,
    output logic pv_chan,
    output logic signed [15:0] pv_value,
    output logic [NCH-1:0] hart_active,
    output logic diag_irq,
    output logic diag_chan,
    output logic limit_irq,
    output logic [NCH-1:0] limit_hi,
    output logic [NCH-1:0] limit_lo,
    output logic eoc_irq
);
    hcp_mod_cfg_s mod_r;
    hcp_phase_e phase_r [NCH];
    logic [NCH-1:0] comm_ok_r;
    logic [NCH-1:0] hart_sel;
    logic [NCH-1:0] need;
    hcp_seq_e sq_r;
    hcp_cmd_s cmd_r;
    logic turn_r;
    logic pick_ch;
    logic [31:0] tmr_r;
    logic done;
    logic timeout;
    logic ok_s;
    logic fail_s;
    logic rec_we_r;
    hcp_rec_s rec_r;
    logic pv_we_r;
    logic pv_chan_r;
    logic signed [15:0] pv_value_r;
    logic diag_r;
    logic diag_chan_r;
    logic limit_r;
    logic [NCH-1:0] lim_hi_r;
    logic [NCH-1:0] lim_lo_r;
    logic [NCH-1:0] hi_ev;
    logic [NCH-1:0] lo_ev;
    logic eoc_r;

    // command owed by a channel in a given phase
    function automatic logic [7:0] code_of(input hcp_phase_e ph);
        if (ph == ph_ident) begin
            return CMD_IDENT;
        end
        if (ph == ph_tag) begin
            return CMD_TAG;
        end
        return CMD_READ_PV;
    endfunction

    // per-channel settings, limits and stop handling
    for (genvar g = 0; g < NCH; g++) begin : g_chan
        hcp_chan_cfg u_cfg (
            .sys_clk(sys_clk),
            .reset(reset),
            .out_module(out_module),
            .cfg_we(cfg_we[g]),
            .cfg_wdata(cfg_wdata),
            .cfg(chan_cfg[g]),
            .hart_sel(hart_sel[g]),
            .pv_we(pv_we_r && pv_chan_r == 1'(g)),
            .pv_value(pv_value_r),
            .hi_exceed(hi_ev[g]),
            .lo_exceed(lo_ev[g]),
            .cpu_stop(cpu_stop),
            .ao_setpoint(ao_setpoint[g]),
            .ao_drive(ao_drive[g])
        );
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mod_r <= MOD_DEFAULT;
        end else if (mod_cfg_we) begin
            mod_r <= mod_cfg_wdata;
        end
    end

    // reply bookkeeping; stray or mismatched replies are dropped
    assign done = (sq_r == sq_wait) && rsp_valid && rsp.chan == cmd_r.chan
               && rsp.code == cmd_r.code;
    assign timeout = (sq_r == sq_wait) && tmr_r == 32'(RSP_TIMEOUT - 1);
    assign ok_s = done && rsp.ok;
    assign fail_s = (done && !rsp.ok) || timeout;

    // channel start-up and run phases
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NCH; i++) begin
                phase_r[i] <= ph_off;
                comm_ok_r[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!hart_sel[i]) begin
                    phase_r[i] <= ph_off;
                    comm_ok_r[i] <= 1'b0;
                end else if (phase_r[i] == ph_off) begin
                    phase_r[i] <= ph_ident;
                end else if (fail_s && cmd_r.chan == i[0]) begin
                    // a lost device is re-identified from scratch
                    phase_r[i] <= ph_ident;
                    comm_ok_r[i] <= 1'b0;
                end else if (ok_s && cmd_r.chan == i[0]) begin
                    comm_ok_r[i] <= 1'b1;
                    if (phase_r[i] == ph_ident) begin
                        phase_r[i] <= ph_tag;
                    end else if (phase_r[i] == ph_tag) begin
                        phase_r[i] <= ph_run;
                    end
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            need[i] = hart_sel[i] && phase_r[i] != ph_off;
            hart_active[i] = hart_sel[i] && phase_r[i] == ph_run && comm_ok_r[i];
        end
    end

    assign pick_ch = need[turn_r] ? turn_r : ~turn_r;

    // one command in flight at a time; the modem is half duplex anyway
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sq_r <= sq_pick;
        end else begin
            unique case (sq_r)
                sq_pick: begin
                    if (|need) begin
                        sq_r <= sq_send;
                    end
                end
                sq_send: begin
                    if (cmd_ready) begin
                        sq_r <= sq_wait;
                    end
                end
                sq_wait: begin
                    if (done || timeout) begin
                        sq_r <= sq_pick;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmd_r <= '{chan: 1'h0, code: CMD_IDENT};
        end else if (sq_r == sq_pick && |need) begin
            cmd_r <= '{chan: pick_ch, code: code_of(phase_r[pick_ch])};
        end
    end
    assign cmd_valid = (sq_r == sq_send);
    assign cmd = cmd_r;

    // hand the turn over after every finished exchange
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            turn_r <= 1'b0;
        end else if (done || timeout) begin
            turn_r <= ~cmd_r.chan;
        end
    end

    // reply timer, only runs while waiting
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tmr_r <= 32'h0000_0000;
        end else if (sq_r == sq_wait) begin
            tmr_r <= tmr_r + 32'h0000_0001;
        end else begin
            tmr_r <= 32'h0000_0000;
        end
    end

    // start-up replies into the diagnostic record
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rec_we_r <= 1'b0;
            rec_r <= '0;
        end else begin
            rec_we_r <= ok_s && cmd_r.code != CMD_READ_PV;
            if (ok_s && cmd_r.code != CMD_READ_PV) begin
                rec_r <= '{num: cmd_r.chan ? REC_DIAG_CH1 : REC_DIAG_CH0,
                           code: cmd_r.code, data: rsp.data};
            end
        end
    end
    assign rec_we = rec_we_r;
    assign rec = rec_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pv_we_r <= 1'b0;
            pv_chan_r <= 1'b0;
            pv_value_r <= 16'sh0000;
        end else begin
            pv_we_r <= ok_s && cmd_r.code == CMD_READ_PV;
            if (ok_s && cmd_r.code == CMD_READ_PV) begin
                pv_chan_r <= cmd_r.chan;
                pv_value_r <= rsp.data[15:0];
            end
        end
    end
    assign pv_we = pv_we_r;
    assign pv_chan = pv_chan_r;
    assign pv_value = pv_value_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            diag_r <= 1'b0;
            diag_chan_r <= 1'b0;
        end else begin
            diag_r <= ok_s && rsp.status[ST_CFG_CHANGED] && mod_r.diag_en;
            if (ok_s && rsp.status[ST_CFG_CHANGED]) begin
                diag_chan_r <= cmd_r.chan;
            end
        end
    end
    assign diag_irq = diag_r;
    assign diag_chan = diag_chan_r;

    // limit and end-of-cycle interrupts, gated by the module enables; limit_hi and limit_lo are not gated
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            limit_r <= 1'b0;
            lim_hi_r <= '0;
            lim_lo_r <= '0;
            eoc_r <= 1'b0;
        end else begin
            limit_r <= mod_r.limit_en && |(hi_ev | lo_ev);
            lim_hi_r <= hi_ev;
            lim_lo_r <= lo_ev;
            // a cycle ends with the last running channel's PV
            eoc_r <= mod_r.eoc_en && ok_s && cmd_r.code == CMD_READ_PV
                  && (cmd_r.chan || phase_r[1] != ph_run);
        end
    end
    assign limit_irq = limit_r;
    assign limit_hi = lim_hi_r;
    assign limit_lo = lim_lo_r;
    assign eoc_irq = eoc_r;

    sequence s_ident_ok;
        ok_s && cmd_r.code == CMD_IDENT;
    endsequence
    sequence s_tag_ok;
        ok_s && cmd_r.code == CMD_TAG;
    endsequence
    sequence s_pv_ok;
        ok_s && cmd_r.code == CMD_READ_PV;
    endsequence

    AST_FIRST_IDENT: assert property (@(posedge sys_clk) disable iff (reset)
        cmd_valid && phase_r[cmd.chan] == ph_ident |-> cmd.code == CMD_IDENT)
        else $error("start-up did not open with identification");
    AST_IDENT_THEN_TAG: assert property (@(posedge sys_clk) disable iff (reset)
        s_ident_ok ##0 hart_sel[cmd_r.chan] |=> phase_r[$past(cmd_r.chan)] == ph_tag)
        else $error("identification not followed by tag");
    AST_REC_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        s_tag_ok |=> rec_we && rec.code == CMD_TAG
        && rec.num == ($past(cmd_r.chan) ? REC_DIAG_CH1 : REC_DIAG_CH0))
        else $error("start-up reply not recorded");
    AST_PV_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        s_pv_ok |=> pv_we && pv_value == $past(rsp.data[15:0]) && !rec_we)
        else $error("primary value not delivered");
    AST_ACTIVE: assert property (@(posedge sys_clk) disable iff (reset)
        !hart_sel[0] || (fail_s && !cmd_r.chan) |=> !hart_active[0])
        else $error("activity shown without live HART");
    AST_DIAG_IRQ: assert property (@(posedge sys_clk) disable iff (reset)
        ok_s && rsp.status[ST_CFG_CHANGED] && mod_r.diag_en |=> diag_irq)
        else $error("parameter change interrupt missing");
    AST_IRQ_GATED: assert property (@(posedge sys_clk) disable iff (reset)
        limit_irq |-> $past(mod_r.limit_en))
        else $error("limit interrupt while disabled");
    AST_ALTERNATE: assert property (@(posedge sys_clk) disable iff (reset)
        s_pv_ok ##1 (sq_r == sq_pick && need[~$past(cmd_r.chan)])
        |=> cmd_r.chan != $past(cmd_r.chan, 2))
        else $error("polling did not alternate");
    AST_TIMEOUT_BOUND: assert property (@(posedge sys_clk) disable iff (reset)
        sq_r == sq_wait |-> tmr_r < 32'(RSP_TIMEOUT))
        else $error("reply wait overran its bound");
endmodule

// ### tb/hcp_field_dev.sv
// hcp_field_dev: behavioural field device seen through the HART modem.
// assumes cmd holds while cmd_valid is high, one exchange at a time.
`timescale 1ns/100ps
module hcp_field_dev import hcp_pkg::*; (
    input wire logic sys_clk,
    input wire logic cmd_valid,
    input wire hcp_cmd_s cmd,
    input wire logic [3:0] slow,
    input wire logic [7:0] status,
    input wire logic signed [15:0] pv [NCH],
    output logic cmd_ready,
    output logic rsp_valid,
    output hcp_rsp_s rsp
);
    hcp_cmd_s c;

    // slow stretches both the accept and the reply
    initial begin
        cmd_ready = 1'b0;
        rsp_valid = 1'b0;
        rsp = '0;
        forever begin
            @(posedge sys_clk);
            if (cmd_valid === 1'b1) begin
                repeat (slow) @(posedge sys_clk);
                cmd_ready <= 1'b1;
                @(posedge sys_clk);
                c = cmd;
                cmd_ready <= 1'b0;
                repeat (slow + 4'h2) @(posedge sys_clk);
                rsp <= {c, 1'b1, status, 39'h0, c, pv[c.chan]};
                rsp_valid <= 1'b1;
                @(posedge sys_clk);
                rsp_valid <= 1'b0;
                // released bus shows garbage, never a stale copy
                rsp <= ~rsp;
            end
        end
    end
endmodule

// ### tb/tb_top.sv
// tb_top: self-checking bench for the two-channel HART poll block.
// assumes hcp_field_dev answers every command it accepts.
`timescale 1ns/100ps
module tb_top import hcp_pkg::*; ;
    logic sys_clk = 1'b0, reset = 1'b1, out_module = 1'b0, mod_cfg_we = 1'b0, cpu_stop = 1'b0;
    logic cmd_valid, cmd_ready, rsp_valid, rec_we, pv_we, pv_chan, diag_irq, diag_chan;
    logic limit_irq, eoc_irq;
    logic [NCH-1:0] cfg_we = '0, hart_active, limit_hi, limit_lo;
    logic [3:0] slow = 4'h2;
    logic [7:0] status = 8'h00;
    logic signed [15:0] pv_value, exp_ao;
    logic signed [15:0] ao_setpoint [NCH] = '{default: 16'sh0000};
    logic signed [15:0] ao_drive [NCH];
    logic signed [15:0] pv [NCH] = '{default: 16'sh0000};
    hcp_mod_cfg_s mod_cfg_wdata = MOD_DEFAULT;
    hcp_chan_cfg_s cfg_wdata = CFG_DEFAULT, c, chan_cfg [NCH];
    hcp_cmd_s cmd;
    hcp_rsp_s rsp;
    hcp_rec_s rec;
    logic [80:0] notes [$];
    int errors = 0, compares = 0, cyc = 0, n_diag = 0, n_lim = 0, n_hi = 0;
    int n_lo = 0, n_eoc = 0, n_dch = 0;

    hcp_poll_top #(.RSP_TIMEOUT(16)) uut (.sys_clk(sys_clk), .reset(reset),
        .out_module(out_module), .mod_cfg_we(mod_cfg_we), .mod_cfg_wdata(mod_cfg_wdata),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .chan_cfg(chan_cfg), .cpu_stop(cpu_stop),
        .ao_setpoint(ao_setpoint), .ao_drive(ao_drive), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
        .rec_we(rec_we), .rec(rec), .pv_we(pv_we), .pv_chan(pv_chan), .pv_value(pv_value),
        .hart_active(hart_active), .diag_irq(diag_irq), .diag_chan(diag_chan),
        .limit_irq(limit_irq), .limit_hi(limit_hi), .limit_lo(limit_lo), .eoc_irq(eoc_irq));
    hcp_field_dev dev (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd), .slow(slow),
        .status(status), .pv(pv), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp));

    always #5 sys_clk = ~sys_clk;

    task automatic judge(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_note(input logic [80:0] g, input logic [80:0] e);
        judge(128'(g), 128'(e));
    endtask
    task automatic chk_cfg(input hcp_chan_cfg_s g, input hcp_chan_cfg_s e);
        judge(128'(g), 128'(e));
    endtask
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        judge(128'(g), 128'(e));
    endtask

    // expected start-up record: number, code, then the reply data
    function automatic logic [80:0] rnote(input logic ch, input logic [7:0] code);
        return {1'b1, ch ? REC_DIAG_CH1 : REC_DIAG_CH0, code, 39'h0, ch, code, pv[ch]};
    endfunction

    task automatic wr(input logic [NCH-1:0] we, input logic mwe, input hcp_chan_cfg_s cc,
                      input hcp_mod_cfg_s md);
        @(posedge sys_clk);
        cfg_we <= we;
        mod_cfg_we <= mwe;
        cfg_wdata <= cc;
        mod_cfg_wdata <= md;
        @(posedge sys_clk);
        cfg_we <= '0;
        mod_cfg_we <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watcher: oldest note against each record or value, plus event counts
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 5000) begin
            errors++;
            finish_test();
        end
        n_diag += int'(diag_irq === 1'b1);
        n_lim += int'(limit_irq === 1'b1);
        n_hi += int'(limit_hi[1] === 1'b1);
        n_lo += int'(limit_lo[0] === 1'b1);
        n_eoc += int'(eoc_irq === 1'b1);
        n_dch += int'(diag_irq === 1'b1 && diag_chan === 1'b1);
        if ((rec_we === 1'b1 || pv_we === 1'b1) && notes.size() > 0) begin
            chk_note(rec_we === 1'b1 ? {1'b1, rec} : {64'h0, pv_chan, pv_value},
                     notes.pop_front());
        end
    end

    initial begin
        void'($urandom(18));
        pv[0] = 16'($urandom_range(16'h3FFF));
        pv[1] = 16'($urandom_range(16'h3FFF)) + 16'sh0100;
        // start-up order, then alternating primary values
        for (int i = 0; i < 8; i++) begin
            notes.push_back(i < 4 ? rnote(i[0], i < 2 ? CMD_IDENT : CMD_TAG)
                                  : {64'h0, i[0], pv[i%2]});
        end
        repeat (12) @(posedge sys_clk);
        chk_cfg(chan_cfg[0], CFG_DEFAULT);
        chk_val(ao_drive[1], 16'h0000);
        chk_val(16'(hart_active), 16'h0000);
        reset <= 1'b0;
        for (int i = 0; i < 600 && notes.size() > 0; i++) @(posedge sys_clk);
        chk_val(16'(notes.size()), 16'h0000);
        chk_val(16'(hart_active), 16'h0003);
        $display("startup test done");
        notes.delete();
        slow <= 4'h0;
        // out-of-range settings saturate, 0-20 mA refused without four-wire
        c = CFG_DEFAULT;
        c.meas = two_wire_transmitter_mode;
        c.range = range_0_20;
        c.hi = 16'sh7F00 + 16'($urandom_range(254));
        c.lo = 16'sh8000;
        c.subst = 16'sh7000;
        wr(2'b01, 1'b0, c, 3'h0);
        c.hi = LIM_TOP;
        c.lo = LIM_BOT;
        c.range = range_4_20;
        c.subst = SUBST_TOP;
        chk_cfg(chan_cfg[0], c);
        chk_val(16'(hart_active), 16'h0002);
        c.meas = four_wire_transmitter_mode;
        c.range = range_0_20;
        wr(2'b01, 1'b0, c, 3'h0);
        chk_cfg(chan_cfg[0], c);
        $display("config test done");
        // events enabled, then disabled while the raw exceed goes on
        c = CFG_DEFAULT;
        c.hi = pv[1] - 16'sh0001;
        c.lo = pv[0] + 16'sh0001;
        status <= 8'h40;
        wr(2'b11, 1'b1, c, 3'h7);
        chk_cfg(chan_cfg[1], c);
        {n_diag, n_lim, n_hi, n_lo, n_eoc, n_dch} = 192'h0;
        repeat (200) @(posedge sys_clk);
        chk_val(16'(n_lim > 0 && n_hi > 0 && n_lo > 0 && n_eoc > 0), 16'h0001);
        chk_val(16'(n_diag > n_dch && n_dch > 0), 16'h0001);
        wr(2'b00, 1'b1, c, 3'h0);
        // pulses launched under the old enables drain for one more cycle
        @(posedge sys_clk);
        {n_diag, n_lim, n_hi, n_lo, n_eoc, n_dch} = 192'h0;
        repeat (200) @(posedge sys_clk);
        chk_val(16'(n_lim + n_diag + n_eoc == 0 && n_hi > 0 && n_lo > 0), 16'h0001);
        $display("event test done");
        // replies slower than the wait bound: HART drops, then comes back
        slow <= 4'hF;
        repeat (200) @(posedge sys_clk);
        chk_val(16'(hart_active), 16'h0000);
        slow <= 4'h0;
        repeat (200) @(posedge sys_clk);
        chk_val(16'(hart_active), 16'h0003);
        $display("timeout test done");
        // each stop reaction against a running setpoint
        for (int m = 0; m < 3; m++) begin
            c = CFG_DEFAULT;
            c.stop = hcp_stop_e'(m);
            c.subst = 16'($urandom_range(20000));
            wr(2'b01, 1'b0, c, 3'h0);
            ao_setpoint[0] <= 16'($urandom);
            repeat (3) @(posedge sys_clk);
            chk_val(ao_drive[0], ao_setpoint[0]);
            exp_ao = m == 0 ? 16'sh0000 : m == 1 ? ao_setpoint[0] : c.subst;
            cpu_stop <= 1'b1;
            ao_setpoint[0] <= ~ao_setpoint[0];
            repeat (3) @(posedge sys_clk);
            chk_val(ao_drive[0], exp_ao);
            cpu_stop <= 1'b0;
        end
        $display("stop test done");
        finish_test();
    end
endmodule
